// ===== core/bsx_pkg.sv
// Package for the bit-skip, call, clear and execute slice of the core.
// Summary of operation
// - Skip-if-one with tested bit set discards next instruction, runs no-op, two cycles.
// - Skip-if-one with tested bit clear lets the next instruction run normally.
// - Both call forms push program counter plus one onto the return stack top.
// - Immediate call loads 11-bit operand to PC[10:0], upper latch bits 6:3 to PC[14:11].
// - Immediate call takes two instruction cycles.
// - Accumulator call pushes the return address in the same cycle as it changes the program counter.
// - Accumulator call loads accumulator to PC[7:0], upper latch bits 6:0 to PC[14:8].
// - Accumulator call takes two instruction cycles.
// - Clear file register writes zero to the addressed register and sets zero flag.
// - Clear accumulator writes zero to the accumulator and sets zero flag.
// - Watchdog kick clears the watchdog counter and its prescaler.
// - Watchdog kick sets both active-low watchdog-expired and sleep-entered flags.
// - Complement inverts the register, destination bit picks target, updates zero flag.
// - Decrement subtracts one, destination bit picks target, updates zero flag.
`default_nettype none

package bsx_pkg;

	localparam int BSX_PC_W = 15;
	localparam int BSX_IR_W = 14;
	localparam logic [14:0] BSX_PC_RST = 15'h0000;
	localparam logic [14:0] BSX_PC_ONE = 15'h0001;
	localparam logic [7:0] BSX_ZERO8 = 8'h00;
	localparam logic [7:0] BSX_ONE8 = 8'h01;

	// Opcode patterns, compared under their masks; the kick and accumulator call match the whole word.
	localparam logic [13:0] BSX_MSK_BTS = 14'h3C00;
	localparam logic [13:0] BSX_OP_BTS = 14'h1C00;
	localparam logic [13:0] BSX_MSK_CALL = 14'h3800;
	localparam logic [13:0] BSX_OP_CALL = 14'h2000;
	localparam logic [13:0] BSX_OP_CALL_VIA_ACCUMULATOR = 14'h000A;
	localparam logic [13:0] BSX_MSK_CLEAR_FILE_REGISTER = 14'h3F80;
	localparam logic [13:0] BSX_OP_CLEAR_FILE_REGISTER = 14'h0180;
	localparam logic [13:0] BSX_MSK_CLEAR_ACCUMULATOR = 14'h3F80;
	localparam logic [13:0] BSX_OP_CLEAR_ACCUMULATOR = 14'h0100;
	localparam logic [13:0] BSX_OP_KICK = 14'h0064;
	localparam logic [13:0] BSX_MSK_FD = 14'h3F00;
	localparam logic [13:0] BSX_OP_COMPLEMENT_FILE = 14'h0900;
	localparam logic [13:0] BSX_OP_DECREMENT_FILE = 14'h0300;

	// Field positions within the instruction word and the upper latch.
	localparam int BSX_F_LSB = 0;
	localparam int BSX_F_MSB = 6;
	localparam int BSX_D_BIT = 7;
	localparam int BSX_B_LSB = 7;
	localparam int BSX_B_MSB = 9;
	localparam int BSX_K_MSB = 10;
	localparam int BSX_LAT_HI = 6;
	localparam int BSX_LAT_MID = 3;

	typedef enum logic [1:0] {
		BSX_ST_EXEC = 2'b00,
		BSX_ST_FLUSH = 2'b01
	} bsx_state_e;

endpackage : bsx_pkg

`default_nettype wire

// ===== core/bsx_exec.sv
// Execution unit for skip, call, clear, complement and decrement instructions.
`default_nettype none

module bsx_exec
	import bsx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic instr_valid_i,
	input wire logic [13:0] instr_i,
	input wire logic [7:0] file_rdata_i,
	input wire logic [7:0] acc_i,
	input wire logic [6:0] pc_upper_latch_i,
	output logic [14:0] pc_o,
	output logic [6:0] file_addr_o,
	output logic file_we_o,
	output logic [7:0] file_wdata_o,
	output logic acc_we_o,
	output logic [7:0] acc_wdata_o,
	output logic zero_we_o,
	output logic zero_o,
	output logic stack_push_o,
	output logic [14:0] stack_top_o,
	output logic wdt_clear_o,
	output logic status_we_o,
	output logic wdt_expired_b_o,
	output logic sleep_entered_b_o,
	output logic busy_o
);

	bsx_state_e state, next_state;
	logic [14:0] pc, next_pc;
	logic [6:0] file_addr, next_file_addr;
	logic file_we, next_file_we;
	logic [7:0] file_wdata, next_file_wdata;
	logic acc_we, next_acc_we;
	logic [7:0] acc_wdata, next_acc_wdata;
	logic zero_we, next_zero_we;
	logic zero, next_zero;
	logic stack_push, next_stack_push;
	logic [14:0] stack_top, next_stack_top;
	logic wdt_clear, next_wdt_clear;
	logic status_we, next_status_we;
	logic wdt_exp_b, next_wdt_exp_b;
	logic sleep_b, next_sleep_b;
	logic busy, next_busy;

	logic [7:0] result;
	logic [14:0] pc_inc;
	logic dst_file;
	logic [7:0] acc_val;

	always_comb begin
		pc_inc = pc + BSX_PC_ONE;
		dst_file = instr_i[BSX_D_BIT];
		acc_val = acc_i;
		result = BSX_ZERO8;
		next_state = state;
		next_pc = pc;
		next_file_addr = instr_i[BSX_F_MSB:BSX_F_LSB];
		next_file_we = 1'b0;
		next_file_wdata = BSX_ZERO8;
		next_acc_we = 1'b0;
		next_acc_wdata = BSX_ZERO8;
		next_zero_we = 1'b0;
		next_zero = zero;
		next_stack_push = 1'b0;
		next_stack_top = stack_top;
		next_wdt_clear = 1'b0;
		next_status_we = 1'b0;
		next_wdt_exp_b = wdt_exp_b;
		next_sleep_b = sleep_b;
		case (state)
		BSX_ST_FLUSH: begin
			// The discarded or refetched slot executes as a no-op.
			next_state = BSX_ST_EXEC;
		end
		BSX_ST_EXEC: begin
			if (instr_valid_i) begin
				// Opcodes outside this slice only move the count on.
				next_pc = pc_inc;
				if ((instr_i & BSX_MSK_BTS) == BSX_OP_BTS) begin
					if (file_rdata_i[instr_i[BSX_B_MSB:BSX_B_LSB]]) begin
						next_pc = pc_inc + BSX_PC_ONE;
						next_state = BSX_ST_FLUSH;
					end
				end else if ((instr_i & BSX_MSK_CALL) == BSX_OP_CALL) begin
					next_stack_push = 1'b1;
					next_stack_top = pc_inc;
					next_pc = {pc_upper_latch_i[BSX_LAT_HI:BSX_LAT_MID],
						instr_i[BSX_K_MSB:0]};
					next_state = BSX_ST_FLUSH;
				end else if (instr_i == BSX_OP_CALL_VIA_ACCUMULATOR) begin
					// Push and jump land together, so the return address is
					// taken from the old count before it changes.
					next_stack_push = 1'b1;
					next_stack_top = pc_inc;
					next_pc = {pc_upper_latch_i, acc_val};
					next_state = BSX_ST_FLUSH;
				end else if ((instr_i & BSX_MSK_CLEAR_FILE_REGISTER) == BSX_OP_CLEAR_FILE_REGISTER) begin
					next_file_we = 1'b1;
					next_file_wdata = BSX_ZERO8;
					next_zero_we = 1'b1;
					next_zero = 1'b1;
				end else if ((instr_i & BSX_MSK_CLEAR_ACCUMULATOR) == BSX_OP_CLEAR_ACCUMULATOR) begin
					next_acc_we = 1'b1;
					next_acc_wdata = BSX_ZERO8;
					next_zero_we = 1'b1;
					next_zero = 1'b1;
				end else if (instr_i == BSX_OP_KICK) begin
					// Both status flags are active low; the kick leaves them inactive.
					next_wdt_clear = 1'b1;
					next_status_we = 1'b1;
					next_wdt_exp_b = 1'b1;
					next_sleep_b = 1'b1;
				end else if ((instr_i & BSX_MSK_FD) == BSX_OP_COMPLEMENT_FILE ||
						(instr_i & BSX_MSK_FD) == BSX_OP_DECREMENT_FILE) begin
					if ((instr_i & BSX_MSK_FD) == BSX_OP_COMPLEMENT_FILE) begin
						result = ~file_rdata_i;
					end else begin
						result = file_rdata_i - BSX_ONE8;
					end
					next_file_we = dst_file;
					next_file_wdata = result;
					next_acc_we = !dst_file;
					next_acc_wdata = result;
					next_zero_we = 1'b1;
					next_zero = (result == BSX_ZERO8);
				end
			end
		end
		default: begin
			next_state = BSX_ST_EXEC;
		end
		endcase
		next_busy = (next_state == BSX_ST_FLUSH);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= BSX_ST_EXEC;
			pc <= BSX_PC_RST;
			file_addr <= BSX_ZERO8[6:0];
			file_we <= 1'b0;
			file_wdata <= BSX_ZERO8;
			acc_we <= 1'b0;
			acc_wdata <= BSX_ZERO8;
			zero_we <= 1'b0;
			zero <= 1'b0;
			stack_push <= 1'b0;
			stack_top <= BSX_PC_RST;
			wdt_clear <= 1'b0;
			status_we <= 1'b0;
			wdt_exp_b <= 1'b1;
			sleep_b <= 1'b1;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			pc <= next_pc;
			file_addr <= next_file_addr;
			file_we <= next_file_we;
			file_wdata <= next_file_wdata;
			acc_we <= next_acc_we;
			acc_wdata <= next_acc_wdata;
			zero_we <= next_zero_we;
			zero <= next_zero;
			stack_push <= next_stack_push;
			stack_top <= next_stack_top;
			wdt_clear <= next_wdt_clear;
			status_we <= next_status_we;
			wdt_exp_b <= next_wdt_exp_b;
			sleep_b <= next_sleep_b;
			busy <= next_busy;
		end
	end

	assign pc_o = pc;
	assign file_addr_o = file_addr;
	assign file_we_o = file_we;
	assign file_wdata_o = file_wdata;
	assign acc_we_o = acc_we;
	assign acc_wdata_o = acc_wdata;
	assign zero_we_o = zero_we;
	assign zero_o = zero;
	assign stack_push_o = stack_push;
	assign stack_top_o = stack_top;
	assign wdt_clear_o = wdt_clear;
	assign status_we_o = status_we;
	assign wdt_expired_b_o = wdt_exp_b;
	assign sleep_entered_b_o = sleep_b;
	// Busy has its own flop, so the pin carries no decode after the state.
	assign busy_o = busy;

	// Checks sit beside the logic; they sample at the clock, reset masks them.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	logic exec_ok;
	logic kick_now;
	assign exec_ok = instr_valid_i && state == BSX_ST_EXEC;
	assign kick_now = exec_ok && instr_i == BSX_OP_KICK;

	chk_skip_taken: assert property (exec_ok &&
		(instr_i & BSX_MSK_BTS) == BSX_OP_BTS &&
		file_rdata_i[instr_i[BSX_B_MSB:BSX_B_LSB]] |=>
		busy_o && pc_o == $past(pc_o) + BSX_PC_ONE + BSX_PC_ONE ##1
		!busy_o)
		else $error("taken skip did not flush one slot");
	chk_skip_not_taken: assert property (exec_ok &&
		(instr_i & BSX_MSK_BTS) == BSX_OP_BTS &&
		!file_rdata_i[instr_i[BSX_B_MSB:BSX_B_LSB]] |=>
		!busy_o && pc_o == $past(pc_o) + BSX_PC_ONE)
		else $error("untaken skip changed flow");
	// Nothing the flushed slot carries may reach memory, stack or count.
	chk_flush_quiet: assert property (busy_o |=>
		!file_we_o && !acc_we_o && !zero_we_o && !stack_push_o &&
		!wdt_clear_o && $stable(pc_o))
		else $error("flushed slot had an effect");

	chk_call_push: assert property (exec_ok &&
		(instr_i & BSX_MSK_CALL) == BSX_OP_CALL |=>
		stack_push_o && stack_top_o == $past(pc_o) + BSX_PC_ONE)
		else $error("call pushed wrong return address");
	chk_call_target: assert property (exec_ok &&
		(instr_i & BSX_MSK_CALL) == BSX_OP_CALL |=>
		pc_o == {$past(pc_upper_latch_i[6:3]), $past(instr_i[10:0])})
		else $error("call target wrong");
	chk_call_cycles: assert property (exec_ok &&
		(instr_i & BSX_MSK_CALL) == BSX_OP_CALL |=>
		busy_o ##1 !busy_o)
		else $error("call did not take two cycles");

	chk_call_via_accumulator_push: assert property (exec_ok &&
		instr_i == BSX_OP_CALL_VIA_ACCUMULATOR |=>
		stack_push_o && stack_top_o == $past(pc_o) + BSX_PC_ONE)
		else $error("accumulator call push wrong");
	chk_call_via_accumulator_target: assert property (exec_ok &&
		instr_i == BSX_OP_CALL_VIA_ACCUMULATOR |=>
		pc_o == {$past(pc_upper_latch_i), $past(acc_i)} ##1 !busy_o)
		else $error("accumulator call target wrong");
	chk_call_via_accumulator_cycles: assert property (exec_ok &&
		instr_i == BSX_OP_CALL_VIA_ACCUMULATOR |=>
		busy_o ##1 !busy_o)
		else $error("accumulator call did not take two cycles");

	chk_clear_file_register_zero: assert property (exec_ok &&
		(instr_i & BSX_MSK_CLEAR_FILE_REGISTER) == BSX_OP_CLEAR_FILE_REGISTER |=>
		file_we_o && file_wdata_o == BSX_ZERO8 && zero_we_o && zero_o)
		else $error("clear register wrong");
	chk_clear_file_register_addr: assert property (exec_ok &&
		(instr_i & BSX_MSK_CLEAR_FILE_REGISTER) == BSX_OP_CLEAR_FILE_REGISTER |=>
		file_addr_o == $past(instr_i[BSX_F_MSB:BSX_F_LSB]))
		else $error("clear register address wrong");
	chk_clear_accumulator_zero: assert property (exec_ok &&
		(instr_i & BSX_MSK_CLEAR_ACCUMULATOR) == BSX_OP_CLEAR_ACCUMULATOR |=>
		acc_we_o && acc_wdata_o == BSX_ZERO8 && zero_o && !file_we_o)
		else $error("clear accumulator wrong");

	// A second kick right behind the first may hold the clear pulse high.
	chk_kick_flags: assert property (kick_now |=>
		wdt_clear_o && status_we_o && wdt_expired_b_o &&
		sleep_entered_b_o ##1 (!wdt_clear_o || $past(kick_now)))
		else $error("watchdog kick wrong");

	chk_complement_file_dest: assert property (exec_ok &&
		(instr_i & BSX_MSK_FD) == BSX_OP_COMPLEMENT_FILE |=>
		file_we_o == $past(instr_i[BSX_D_BIT]) &&
		acc_we_o != file_we_o &&
		file_wdata_o == ~$past(file_rdata_i) &&
		zero_o == (file_wdata_o == BSX_ZERO8))
		else $error("complement result wrong");
	chk_decrement_file_dest: assert property (exec_ok &&
		(instr_i & BSX_MSK_FD) == BSX_OP_DECREMENT_FILE |=>
		file_we_o == $past(instr_i[BSX_D_BIT]) &&
		acc_we_o != file_we_o &&
		acc_wdata_o == $past(file_rdata_i) - BSX_ONE8)
		else $error("decrement result wrong");
	chk_decrement_file_zero: assert property (exec_ok &&
		(instr_i & BSX_MSK_FD) == BSX_OP_DECREMENT_FILE |=>
		zero_we_o && zero_o == ($past(file_rdata_i) == BSX_ONE8))
		else $error("decrement zero flag wrong");
	chk_single_cycle: assert property (exec_ok &&
		(instr_i == BSX_OP_KICK ||
		(instr_i & BSX_MSK_CLEAR_FILE_REGISTER) == BSX_OP_CLEAR_FILE_REGISTER ||
		(instr_i & BSX_MSK_CLEAR_ACCUMULATOR) == BSX_OP_CLEAR_ACCUMULATOR) |=>
		!busy_o && pc_o == $past(pc_o) + BSX_PC_ONE)
		else $error("single-cycle instruction stalled");
	chk_fd_single: assert property (exec_ok &&
		((instr_i & BSX_MSK_FD) == BSX_OP_COMPLEMENT_FILE ||
		(instr_i & BSX_MSK_FD) == BSX_OP_DECREMENT_FILE) |=>
		!busy_o && pc_o == $past(pc_o) + BSX_PC_ONE)
		else $error("complement or decrement stalled");

	// Covers show the main flows: taken skip, both calls, kick, zero result.
	cov_skip_taken: cover property (exec_ok &&
		(instr_i & BSX_MSK_BTS) == BSX_OP_BTS ##1 busy_o);
	cov_call: cover property (exec_ok &&
		(instr_i & BSX_MSK_CALL) == BSX_OP_CALL);
	cov_call_via_accumulator: cover property (exec_ok && instr_i == BSX_OP_CALL_VIA_ACCUMULATOR);
	cov_decrement_file_zero: cover property (exec_ok &&
		(instr_i & BSX_MSK_FD) == BSX_OP_DECREMENT_FILE ##1 zero_o);
	cov_kick: cover property (kick_now ##1 wdt_clear_o);

endmodule : bsx_exec

`default_nettype wire

// ===== dv/bsx_mem_model.sv
// Behavioural file registers, accumulator and return stack for the bench.
`default_nettype none

module bsx_mem_model (
	input wire logic clk_i,
	input wire logic [6:0] rd_addr_i,
	output logic [7:0] rdata_o,
	input wire logic file_we_i,
	input wire logic [6:0] file_addr_i,
	input wire logic [7:0] file_wdata_i,
	input wire logic acc_we_i,
	input wire logic [7:0] acc_wdata_i,
	output logic [7:0] acc_o,
	input wire logic push_i,
	input wire logic [14:0] top_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [128];
	logic [7:0] acc;
	logic [14:0] stk;
	// The read is combinational, as the core fetches the operand in-cycle.
	assign rdata_o = mem[rd_addr_i];
	assign acc_o = acc;
	initial begin
		acc = 8'h00;
		for (int i = 0; i < 128; i++) mem[i] = 8'h00;
	end
	always @(posedge clk_i) begin
		if (file_we_i) mem[file_addr_i] <= file_wdata_i;
		if (acc_we_i) acc <= acc_wdata_i;
		if (push_i) stk <= top_i;
	end
endmodule : bsx_mem_model

`default_nettype wire

// ===== dv/bit_skip_call_clear_exec_bench.sv
// Self-checking bench for the skip, call, clear and execute slice.
`default_nettype none

module bit_skip_call_clear_exec_bench
	import bsx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic instr_valid_i = 1'b0;
	logic [13:0] instr_i = 14'h0000;
	logic [6:0] pc_upper_latch_i = 7'h00;
	logic [7:0] file_rdata_i, acc_i, file_wdata_o, acc_wdata_o;
	logic [14:0] pc_o, stack_top_o, exp_pc;
	logic [6:0] file_addr_o;
	logic file_we_o, acc_we_o, zero_we_o, zero_o, stack_push_o, wdt_clear_o;
	logic status_we_o, wdt_expired_b_o, sleep_entered_b_o, busy_o;
	int failures = 0;
	int n_tests = 0;

	bsx_exec dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.file_rdata_i(file_rdata_i), .acc_i(acc_i),
		.pc_upper_latch_i(pc_upper_latch_i), .pc_o(pc_o),
		.file_addr_o(file_addr_o), .file_we_o(file_we_o),
		.file_wdata_o(file_wdata_o), .acc_we_o(acc_we_o),
		.acc_wdata_o(acc_wdata_o), .zero_we_o(zero_we_o), .zero_o(zero_o),
		.stack_push_o(stack_push_o), .stack_top_o(stack_top_o),
		.wdt_clear_o(wdt_clear_o), .status_we_o(status_we_o),
		.wdt_expired_b_o(wdt_expired_b_o),
		.sleep_entered_b_o(sleep_entered_b_o), .busy_o(busy_o));
	bsx_mem_model mem_u (.clk_i(clk_i), .rd_addr_i(instr_i[6:0]),
		.rdata_o(file_rdata_i), .file_we_i(file_we_o),
		.file_addr_i(file_addr_o), .file_wdata_i(file_wdata_o),
		.acc_we_i(acc_we_o), .acc_wdata_i(acc_wdata_o), .acc_o(acc_i),
		.push_i(stack_push_o), .top_i(stack_top_o));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic chk(input bit ok, input string msg);
		n_tests++;
		if (!ok) begin
			$display("ERROR %0t %s", $time, msg);
			failures++;
		end
	endtask : chk

	// Called at a falling edge; returns at the next one with outputs settled.
	task automatic step(input logic [13:0] ins, input logic v);
		instr_i = ins;
		instr_valid_i = v;
		@(negedge clk_i);
		if (v) exp_pc = exp_pc + 15'h0001;
	endtask : step

	task automatic t_fd();
		logic [7:0] v, r;
		logic [6:0] f;
		for (int i = 0; i < 8; i++) begin
			v = i[2] ? (i[1] ? 8'h00 : 8'h5A) : (i[1] ? 8'h01 : 8'hFF);
			r = i[1] ? v - 8'h01 : ~v;
			f = 7'h10 + 7'(i);
			mem_u.mem[f] = v;
			step((i[1] ? BSX_OP_DECREMENT_FILE : BSX_OP_COMPLEMENT_FILE) | {6'h00, i[0], f}, 1'b1);
			chk(file_we_o === i[0] && acc_we_o === !i[0], "dest");
			chk((i[0] ? file_wdata_o : acc_wdata_o) === r, "data");
			chk(zero_we_o === 1'b1 && zero_o === (r == 8'h00), "z");
			chk(pc_o === exp_pc, "pc");
		end
		$display("t_fd done");
	endtask : t_fd

	task automatic t_clear();
		step(BSX_OP_CLEAR_ACCUMULATOR, 1'b1);
		chk(acc_we_o === 1'b1 && acc_wdata_o === 8'h00, "acc");
		chk(zero_we_o === 1'b1 && zero_o === 1'b1, "z");
		mem_u.mem[127] = 8'h00;
		step(BSX_OP_COMPLEMENT_FILE | 14'h007F, 1'b1);
		chk(zero_o === 1'b0, "z0");
		mem_u.mem[127] = 8'h3C;
		step(BSX_OP_CLEAR_FILE_REGISTER | 14'h007F, 1'b1);
		chk(file_we_o === 1'b1 && file_addr_o === 7'h7F, "we");
		chk(file_wdata_o === 8'h00 && zero_o === 1'b1, "clr");
		chk(pc_o === exp_pc, "pc");
		step(14'h0000, 1'b1);
		chk(mem_u.mem[127] === 8'h00 && file_we_o === 1'b0, "mem");
		chk(pc_o === exp_pc && acc_we_o === 1'b0, "unknown");
		chk(zero_we_o === 1'b0 && busy_o === 1'b0, "unk z");
		$display("t_clear done");
	endtask : t_clear

	task automatic t_kick();
		step(BSX_OP_KICK, 1'b1);
		chk(wdt_clear_o === 1'b1 && status_we_o === 1'b1, "kick");
		chk(wdt_expired_b_o === 1'b1 && sleep_entered_b_o === 1'b1, "fl");
		chk(pc_o === exp_pc && busy_o === 1'b0, "pc");
		step(14'h0000, 1'b0);
		chk(wdt_clear_o === 1'b0, "pulse");
		$display("t_kick done");
	endtask : t_kick

	task automatic t_skip();
		for (int b = 0; b < 8; b += 7) begin
			mem_u.mem[9] = 8'h01 << b;
			step(BSX_OP_BTS | {4'h0, 3'(b), 7'h09}, 1'b1);
			exp_pc = exp_pc + 15'h0001;
			chk(pc_o === exp_pc && busy_o === 1'b1, "taken");
			step(BSX_OP_CLEAR_ACCUMULATOR, 1'b1);
			exp_pc = exp_pc - 15'h0001;
			chk(acc_we_o === 1'b0 && busy_o === 1'b0, "flush");
			chk(pc_o === exp_pc, "pc");
			mem_u.mem[9] = ~(8'h01 << b);
			step(BSX_OP_BTS | {4'h0, 3'(b), 7'h09}, 1'b1);
			chk(pc_o === exp_pc && busy_o === 1'b0, "untaken");
			step(BSX_OP_CLEAR_ACCUMULATOR, 1'b1);
			chk(acc_we_o === 1'b1 && pc_o === exp_pc, "next");
		end
		$display("t_skip done");
	endtask : t_skip

	task automatic t_call(input bit via_acc);
		logic [14:0] ret;
		ret = exp_pc + 15'h0001;
		pc_upper_latch_i = via_acc ? 7'h2D : 7'h5A;
		mem_u.acc = 8'hC3;
		step(via_acc ? BSX_OP_CALL_VIA_ACCUMULATOR : (BSX_OP_CALL | 14'h0123), 1'b1);
		exp_pc = via_acc ? 15'h2DC3 : 15'h5923;
		chk(pc_o === exp_pc, "target");
		chk(stack_push_o === 1'b1 && stack_top_o === ret, "push");
		chk(busy_o === 1'b1, "busy");
		step(BSX_OP_CLEAR_ACCUMULATOR, 1'b1);
		exp_pc = exp_pc - 15'h0001;
		chk(busy_o === 1'b0 && acc_we_o === 1'b0, "slot");
		chk(stack_push_o === 1'b0 && pc_o === exp_pc, "hold");
		chk(mem_u.stk === ret, "stack");
		$display("t_call done");
	endtask : t_call

	task automatic t_reset();
		mem_u.mem[9] = 8'h01;
		step(BSX_OP_BTS | 14'h0009, 1'b1);
		chk(busy_o === 1'b1, "busy");
		rst_b_i = 1'b0;
		instr_valid_i = 1'b0;
		@(negedge clk_i);
		chk(pc_o === BSX_PC_RST && busy_o === 1'b0, "mid rst");
		chk(stack_top_o === BSX_PC_RST && zero_o === 1'b0, "rst st");
		rst_b_i = 1'b1;
		exp_pc = BSX_PC_RST;
		step(BSX_OP_CLEAR_ACCUMULATOR, 1'b1);
		chk(pc_o === exp_pc && acc_we_o === 1'b1, "after");
		$display("t_reset done");
	endtask : t_reset

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#20000;
		failures++;
		tally_and_finish();
	end

	initial begin
		exp_pc = BSX_PC_RST;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk(pc_o === 15'h0000 && busy_o === 1'b0 && zero_o === 1'b0, "rst");
		rst_b_i = 1'b1;
		t_fd();
		t_clear();
		t_kick();
		t_skip();
		t_call(1'b0);
		t_call(1'b1);
		t_reset();
		tally_and_finish();
	end
endmodule : bit_skip_call_clear_exec_bench

`default_nettype wire
